/* File: ocdt_top.sv */
// three overcurrent functions, each with high, low and curve stages
// for three phases and the residual path
// assumes the front end gives per-location fundamental and
// second-harmonic magnitudes, the residual being of the phase sum
//
// Notes on behaviour
// RL1 - residual uses phase sum of its location
// RL2 - phase and residual pick locations independently
// RL3 - single-phase busbar object disables every stage; path inrush flags still run
// RL4 - two fixed stages plus curve stage per path
// RL5 - fixed stages run whatever the curve setting
// RL6 - three independent instances, own settings, own outputs
// RL7 - high stage compares per phase and residual
// RL8 - high stage trips after its delay
// RL9 - high dropout 95 percent, lower when small
// RL10 - low stage shared phase threshold, separate residual
// RL11 - inrush gives inrush message instead of pickup
// RL12 - inrush blocks trip but expiry still flagged
// RL13 - trip and expiry separate for every stage
// RL14 - low dropout 95 percent, wider when small
// RL15 - each stage threshold and delay set separately
// RL16 - all pickups and trips ORed into groups
// RL17 - restraint never touches the high stage
// RL18 - second harmonic above ratio flags path inrush
// RL19 - timer counts during pickup, clears on dropout
`default_nettype none
module ocdt_top (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic object_is_1ph_busbar,
  input wire logic [ocdt_pkg::NLOC-1:0][2:0][ocdt_pkg::MAG_W-1:0]
    loc_phase_mag,
  input wire logic [ocdt_pkg::NLOC-1:0][ocdt_pkg::MAG_W-1:0]
    loc_residual_mag,
  input wire logic [ocdt_pkg::NLOC-1:0][2:0][ocdt_pkg::MAG_W-1:0]
    loc_phase_h2,
  input wire logic [ocdt_pkg::NLOC-1:0][ocdt_pkg::MAG_W-1:0]
    loc_residual_h2,
  input wire logic [ocdt_pkg::NINST-1:0] function_on,
  input wire logic [ocdt_pkg::NINST-1:0][ocdt_pkg::LOC_W-1:0] phase_loc,
  input wire logic [ocdt_pkg::NINST-1:0][ocdt_pkg::LOC_W-1:0] residual_loc,
  input wire logic [ocdt_pkg::NINST-1:0] phase_curve_on,
  input wire logic [ocdt_pkg::NINST-1:0] residual_curve_on,
  input wire logic [ocdt_pkg::NINST-1:0] inrush_restraint_on,
  input wire logic [ocdt_pkg::NINST-1:0][ocdt_pkg::RATIO_W-1:0]
    inrush_h2_ratio,
  input wire logic [ocdt_pkg::NINST-1:0][ocdt_pkg::MAG_W-1:0]
    phase_high_set_threshold,
  input wire logic [ocdt_pkg::NINST-1:0][ocdt_pkg::TMR_W-1:0]
    phase_high_set_delay,
  input wire logic [ocdt_pkg::NINST-1:0][ocdt_pkg::MAG_W-1:0]
    phase_low_set_threshold,
  input wire logic [ocdt_pkg::NINST-1:0][ocdt_pkg::TMR_W-1:0]
    phase_low_set_delay,
  input wire logic [ocdt_pkg::NINST-1:0][ocdt_pkg::MAG_W-1:0]
    phase_curve_threshold,
  input wire logic [ocdt_pkg::NINST-1:0][ocdt_pkg::TMR_W-1:0]
    phase_curve_factor,
  input wire logic [ocdt_pkg::NINST-1:0][ocdt_pkg::MAG_W-1:0]
    residual_high_set_threshold,
  input wire logic [ocdt_pkg::NINST-1:0][ocdt_pkg::TMR_W-1:0]
    residual_high_set_delay,
  input wire logic [ocdt_pkg::NINST-1:0][ocdt_pkg::MAG_W-1:0]
    residual_low_set_threshold,
  input wire logic [ocdt_pkg::NINST-1:0][ocdt_pkg::TMR_W-1:0]
    residual_low_set_delay,
  input wire logic [ocdt_pkg::NINST-1:0][ocdt_pkg::MAG_W-1:0]
    residual_curve_threshold,
  input wire logic [ocdt_pkg::NINST-1:0][ocdt_pkg::TMR_W-1:0]
    residual_curve_factor,
  output logic [ocdt_pkg::NINST-1:0][ocdt_pkg::NKIND-1:0]
    [ocdt_pkg::NCH-1:0] stage_pickup,
  output logic [ocdt_pkg::NINST-1:0][ocdt_pkg::NKIND-1:0]
    [ocdt_pkg::NCH-1:0] stage_inrush,
  output logic [ocdt_pkg::NINST-1:0][ocdt_pkg::NKIND-1:0]
    [ocdt_pkg::NCH-1:0] stage_expired,
  output logic [ocdt_pkg::NINST-1:0][ocdt_pkg::NKIND-1:0]
    [ocdt_pkg::NCH-1:0] stage_trip,
  output logic [ocdt_pkg::NINST-1:0][ocdt_pkg::NCH-1:0] path_inrush,
  output logic [ocdt_pkg::NINST-1:0] instance_active,
  output logic group_pickup_flag,
  output logic group_trip_flag
);
  typedef struct packed {
    logic [ocdt_pkg::NINST-1:0][ocdt_pkg::NCH-1:0] inrush;
    logic [ocdt_pkg::NINST-1:0] active;
    logic group_pu;
    logic group_trip;
  } ocdt_top_st_t;

  ocdt_top_st_t st_q;
  ocdt_top_st_t st_d;

  // selected magnitudes per instance and channel
  logic [ocdt_pkg::NINST-1:0][ocdt_pkg::NCH-1:0][ocdt_pkg::MAG_W-1:0] fund;
  logic [ocdt_pkg::NINST-1:0][ocdt_pkg::NCH-1:0][ocdt_pkg::MAG_W-1:0] h2;
  logic [ocdt_pkg::NINST-1:0][ocdt_pkg::NKIND-1:0][ocdt_pkg::NCH-1:0] pu_w;
  logic [ocdt_pkg::NINST-1:0][ocdt_pkg::NKIND-1:0][ocdt_pkg::NCH-1:0] inr_w;
  logic [ocdt_pkg::NINST-1:0][ocdt_pkg::NKIND-1:0][ocdt_pkg::NCH-1:0] exp_w;
  logic [ocdt_pkg::NINST-1:0][ocdt_pkg::NKIND-1:0][ocdt_pkg::NCH-1:0] trp_w;

  for (genvar gi = 0; gi < ocdt_pkg::NINST; gi++) begin : g_inst
    for (genvar gc = 0; gc < ocdt_pkg::NCH; gc++) begin : g_ch
      if (gc == ocdt_pkg::CH_RES) begin : g_res
        // residual follows its own location, not the phase one
        assign fund[gi][gc] = loc_residual_mag[residual_loc[gi]]; // [RL1] [RL2]
        assign h2[gi][gc] = loc_residual_h2[residual_loc[gi]]; // [RL2]
      end else begin : g_ph
        assign fund[gi][gc] = loc_phase_mag[phase_loc[gi]][gc]; // [RL2]
        assign h2[gi][gc] = loc_phase_h2[phase_loc[gi]][gc]; // [RL2]
      end
      for (genvar gk = 0; gk < ocdt_pkg::NKIND; gk++) begin : g_kind
        localparam bit IS_RES = (gc == ocdt_pkg::CH_RES);
        localparam bit IS_HIGH = (gk == ocdt_pkg::KIND_HIGH);
        localparam bit IS_CURVE = (gk == ocdt_pkg::KIND_CURVE);
        logic [ocdt_pkg::MAG_W-1:0] thr_set;
        logic [ocdt_pkg::TMR_W-1:0] dly_set;
        logic [ocdt_pkg::MAG_W:0] thr_ext;
        logic curve_on;
        ocdt_stage_if sif ();
        if (gk == ocdt_pkg::KIND_HIGH) begin : g_h
          assign thr_set = IS_RES ? residual_high_set_threshold[gi]
                                  : phase_high_set_threshold[gi]; // [RL15]
          assign dly_set = IS_RES ? residual_high_set_delay[gi]
                                  : phase_high_set_delay[gi]; // [RL15]
        end else if (gk == ocdt_pkg::KIND_LOW) begin : g_l
          assign thr_set = IS_RES ? residual_low_set_threshold[gi]
                                  : phase_low_set_threshold[gi]; // [RL15]
          assign dly_set = IS_RES ? residual_low_set_delay[gi]
                                  : phase_low_set_delay[gi]; // [RL15]
        end else begin : g_c
          assign thr_set = IS_RES ? residual_curve_threshold[gi]
                                  : phase_curve_threshold[gi];
          assign dly_set = IS_RES ? residual_curve_factor[gi]
                                  : phase_curve_factor[gi];
        end
        assign curve_on = IS_RES ? residual_curve_on[gi] : phase_curve_on[gi];
        // curve stage picks up at 1.1 times its setting, saturated
        assign thr_ext = {1'b0, thr_set} + ({1'b0, thr_set} /
                                            ocdt_pkg::CURVE_PICKUP_DIV);
        assign sif.mag = fund[gi][gc];
        assign sif.thr = !IS_CURVE ? thr_set :
                         thr_ext[ocdt_pkg::MAG_W] ? ocdt_pkg::MAG_MAX :
                         thr_ext[ocdt_pkg::MAG_W-1:0]; // [RL4]
        assign sif.delay = dly_set;
        // the curve stage integrates current, so heavier faults trip
        // sooner; a crude inverse law standing in for the full curves
        assign sif.delta = IS_CURVE ? fund[gi][gc]
                                    : {{(ocdt_pkg::MAG_W-1){1'b0}}, 1'b1};
        assign sif.inrush = st_q.inrush[gi][gc];
        assign sif.restraint_on = inrush_restraint_on[gi];
        // fixed stages ignore the curve switch entirely
        assign sif.active = st_q.active[gi] &
                            (!IS_CURVE | curve_on); // [RL5] [RL4]
        ocdt_stage #(
          .DROP_SMALL(IS_HIGH ? ocdt_pkg::DROP_HIGH_SMALL
                              : ocdt_pkg::DROP_LOW_SMALL),
          .USE_RESTRAINT(!IS_HIGH)
        ) u_stage (
          .ref_clk(ref_clk),
          .rstn(rstn),
          .s(sif.stage)
        ); // [RL6] [RL17]
        assign pu_w[gi][gk][gc] = sif.pickup;
        assign inr_w[gi][gk][gc] = sif.inrush_pu;
        assign exp_w[gi][gk][gc] = sif.expired;
        assign trp_w[gi][gk][gc] = sif.trip;
      end
    end
  end

  always_comb begin
    logic [ocdt_pkg::MAG_W+ocdt_pkg::RATIO_W-1:0] lhs;
    logic [ocdt_pkg::MAG_W+ocdt_pkg::RATIO_W-1:0] rhs;
    lhs = '0;
    rhs = '0;
    st_d = st_q;
    for (int i = 0; i < ocdt_pkg::NINST; i++) begin
      st_d.active[i] = function_on[i] & ~object_is_1ph_busbar; // [RL3]
      for (int c = 0; c < ocdt_pkg::NCH; c++) begin
        // h2 / fund > ratio / 256, done without a divider
        lhs = {h2[i][c], {ocdt_pkg::RATIO_SHIFT{1'b0}}};
        rhs = fund[i][c] * inrush_h2_ratio[i];
        st_d.inrush[i][c] = (lhs > rhs); // [RL18]
      end
    end
    // inrush messages count as fault annunciations too
    st_d.group_pu = |{pu_w, inr_w}; // [RL16]
    st_d.group_trip = |trp_w; // [RL16]
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // stage flags come straight from the stage flip-flops
  assign stage_pickup = pu_w;
  assign stage_inrush = inr_w;
  assign stage_expired = exp_w; // [RL13]
  assign stage_trip = trp_w; // [RL13]
  assign path_inrush = st_q.inrush;
  assign instance_active = st_q.active;
  assign group_pickup_flag = st_q.group_pu;
  assign group_trip_flag = st_q.group_trip;
endmodule // ocdt_top
`default_nettype wire

/* File: ocdt_pkg.sv */
// constants shared by the overcurrent stage logic
// assumes magnitudes arrive as unsigned fundamental-wave values per tick
`default_nettype none
package ocdt_pkg;
  localparam int NINST = 3;
  localparam int NLOC = 4;
  localparam int LOC_W = 2;
  localparam int NCH = 4;
  localparam int NKIND = 3;
  localparam int MAG_W = 16;
  localparam int TMR_W = 32;
  localparam int RATIO_W = 8;
  localparam int RATIO_SHIFT = 8;
  // channel and stage kind indices
  localparam int CH_RES = 3;
  localparam int KIND_HIGH = 0;
  localparam int KIND_LOW = 1;
  localparam int KIND_CURVE = 2;
  // rated current in magnitude units
  localparam logic [MAG_W-1:0] RATED_MAG = 16'h1000;
  // dropout ratios in 1/256 units
  localparam logic [RATIO_W-1:0] DROP_BIG = 8'hf3;
  localparam logic [RATIO_W-1:0] DROP_HIGH_SMALL = 8'he6;
  localparam logic [RATIO_W-1:0] DROP_LOW_SMALL = 8'hcd;
  // curve stage picks up at threshold plus one tenth
  localparam logic [MAG_W:0] CURVE_PICKUP_DIV = 17'h0000a;
  localparam logic [MAG_W-1:0] MAG_MAX = 16'hffff;
  localparam logic [TMR_W-1:0] TMR_MAX = 32'hffffffff;
  localparam logic [TMR_W-1:0] TMR_ZERO = 32'h00000000;
endpackage
`default_nettype wire

/* File: ocdt_stage_if.sv */
// carrier between the top and one stage: settings in, flags out
// assumes the top drives settings and the stage drives results
`default_nettype none
interface ocdt_stage_if;
  logic [ocdt_pkg::MAG_W-1:0] mag;
  logic [ocdt_pkg::MAG_W-1:0] thr;
  logic [ocdt_pkg::TMR_W-1:0] delay;
  logic [ocdt_pkg::MAG_W-1:0] delta;
  logic inrush;
  logic restraint_on;
  logic active;
  logic pickup;
  logic inrush_pu;
  logic expired;
  logic trip;
  modport stage (
    input mag, thr, delay, delta, inrush, restraint_on, active,
    output pickup, inrush_pu, expired, trip
  );
  modport owner (
    output mag, thr, delay, delta, inrush, restraint_on, active,
    input pickup, inrush_pu, expired, trip
  );
endinterface
`default_nettype wire

/* File: ocdt_stage.sv */
// one comparator with hysteresis, delay timer and trip gate
// assumes settings stay steady while a pickup is in progress
`default_nettype none
module ocdt_stage #(
  parameter logic [ocdt_pkg::RATIO_W-1:0] DROP_SMALL = 8'he6,
  parameter logic USE_RESTRAINT = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rstn,
  ocdt_stage_if.stage s
);
  typedef struct packed {
    logic [ocdt_pkg::TMR_W-1:0] cnt;
    logic picked;
    logic pickup;
    logic inrush_pu;
    logic expired;
    logic trip;
  } ocdt_stage_st_t;

  ocdt_stage_st_t st_q;
  ocdt_stage_st_t st_d;

  always_comb begin
    logic [ocdt_pkg::RATIO_W-1:0] ratio;
    logic [ocdt_pkg::MAG_W+ocdt_pkg::RATIO_W-1:0] prod;
    logic [ocdt_pkg::MAG_W-1:0] drop_lvl;
    logic [ocdt_pkg::TMR_W:0] sum;
    logic restrained;
    ratio = '0;
    prod = '0;
    drop_lvl = '0;
    sum = '0;
    restrained = 1'b0;
    st_d = st_q;
    // small settings get a wider band against chatter near threshold
    ratio = (s.thr > ocdt_pkg::RATED_MAG) ? ocdt_pkg::DROP_BIG
                                          : DROP_SMALL; // [RL9] [RL14]
    prod = s.thr * ratio;
    drop_lvl = prod[ocdt_pkg::MAG_W+ocdt_pkg::RATIO_W-1:ocdt_pkg::RATIO_SHIFT];
    restrained = USE_RESTRAINT & s.restraint_on & s.inrush; // [RL17]
    if (!s.active) begin
      st_d.picked = 1'b0; // [RL3]
    end else if (s.mag > s.thr) begin
      st_d.picked = 1'b1; // [RL7] [RL10]
    end else if (s.mag < drop_lvl) begin
      st_d.picked = 1'b0; // [RL9] [RL14]
    end
    sum = {1'b0, st_q.cnt} + {{(ocdt_pkg::TMR_W-ocdt_pkg::MAG_W+1){1'b0}},
                              s.delta};
    if (!st_d.picked) begin
      st_d.cnt = ocdt_pkg::TMR_ZERO; // [RL19]
    end else if (st_q.picked) begin
      st_d.cnt = sum[ocdt_pkg::TMR_W] ? ocdt_pkg::TMR_MAX
                                      : sum[ocdt_pkg::TMR_W-1:0]; // [RL19]
    end
    st_d.expired = st_d.picked & (st_d.cnt >= s.delay); // [RL8] [RL13]
    // inrush replaces the normal pickup, never both
    st_d.pickup = st_d.picked & ~restrained; // [RL11]
    st_d.inrush_pu = st_d.picked & restrained; // [RL11]
    st_d.trip = st_d.expired & ~restrained; // [RL12] [RL18]
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign s.pickup = st_q.pickup;
  assign s.inrush_pu = st_q.inrush_pu;
  assign s.expired = st_q.expired;
  assign s.trip = st_q.trip;
endmodule // ocdt_stage
`default_nettype wire

/* File: ocdt_properties.sv */
// checker for the overcurrent top: flag timing and exclusions
// assumes it is bound to ocdt_top and sees only its ports
`default_nettype none
module ocdt_checker (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic object_is_1ph_busbar,
  input wire logic [2:0][31:0] phase_high_set_delay,
  input wire logic [2:0][2:0][3:0] stage_pickup,
  input wire logic [2:0][2:0][3:0] stage_inrush,
  input wire logic [2:0][2:0][3:0] stage_expired,
  input wire logic [2:0][2:0][3:0] stage_trip,
  input wire logic group_pickup_flag,
  input wire logic group_trip_flag
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  busbar_stops_all_a: assert property (
    object_is_1ph_busbar [*2] |=> stage_pickup == '0 && stage_trip == '0)
    else $error("stage active under busbar object");
  trip_needs_expiry_a: assert property (
    (stage_trip & ~stage_expired) == '0) else $error("trip before expiry");
  restrained_no_trip_a: assert property (
    (stage_trip & stage_inrush) == '0) else $error("trip during inrush");
  pickup_or_inrush_a: assert property (
    (stage_pickup & stage_inrush) == '0) else $error("pickup and inrush");
  high_never_held_a: assert property (
    stage_inrush[0][0] == '0 && stage_inrush[1][0] == '0 &&
    stage_inrush[2][0] == '0) else $error("high stage restrained");
  group_pickup_or_a: assert property (
    group_pickup_flag == $past(|(stage_pickup | stage_inrush)))
    else $error("group pickup wrong");
  group_trip_or_a: assert property (
    group_trip_flag == $past(|stage_trip)) else $error("group trip wrong");
  high_delay_count_a: assert property (
    $rose(stage_pickup[0][0][0]) && phase_high_set_delay[0] == 32'h3
    |-> ##2 !stage_expired[0][0][0] ##1 stage_expired[0][0][0])
    else $error("high stage delay wrong");
endmodule // ocdt_checker
bind ocdt_top ocdt_checker i_ocdt_checker (.ref_clk, .rstn,
  .object_is_1ph_busbar, .phase_high_set_delay, .stage_pickup,
  .stage_inrush, .stage_expired, .stage_trip, .group_pickup_flag,
  .group_trip_flag);
`default_nettype wire

/* File: ocdt_front_end.sv */
// front-end model: fundamental and h2 magnitudes per location
// assumes the bench names the locations that carry current
`default_nettype none
module ocdt_front_end (
  input wire logic ref_clk,
  input wire logic [1:0] ph_loc,
  input wire logic [1:0] res_loc,
  input wire logic [15:0] ph_mag,
  input wire logic [15:0] ph_h2,
  input wire logic [15:0] res_mag,
  output logic [3:0][2:0][15:0] loc_phase_mag,
  output logic [3:0][2:0][15:0] loc_phase_h2,
  output logic [3:0][15:0] loc_residual_mag,
  output logic [3:0][15:0] loc_residual_h2
);
  // idle locations carry no current; phases b and c run at a sixteenth
  // of phase a so that only one phase crosses a threshold
  always_ff @(posedge ref_clk) begin
    loc_phase_mag <= '0;
    loc_phase_h2 <= '0;
    loc_residual_mag <= '0;
    loc_residual_h2 <= '0;
    loc_phase_mag[ph_loc] <= {ph_mag >> 4, ph_mag >> 4, ph_mag};
    loc_phase_h2[ph_loc][0] <= ph_h2;
    loc_residual_mag[res_loc] <= res_mag;
  end
endmodule // ocdt_front_end
`default_nettype wire

/* File: ocdt_top_test.sv */
// bench for the overcurrent top: pickup, dropout, inrush, busbar tests
// assumes the front-end model delays every magnitude by one tick
`default_nettype none
module ocdt_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk;
  logic rstn;
  logic object_is_1ph_busbar = 1'b0;
  logic [2:0] function_on = 3'h3;
  logic [2:0][1:0] phase_loc = 6'h01;
  logic [2:0][1:0] residual_loc = 6'h02;
  logic [2:0] phase_curve_on = 3'h1;
  logic [2:0] residual_curve_on = 3'h0;
  logic [2:0] inrush_restraint_on = 3'h7;
  logic [2:0][7:0] inrush_h2_ratio = {3{8'h26}};
  logic [2:0][15:0] phase_high_set_threshold = {3{16'h2000}};
  logic [2:0][15:0] phase_low_set_threshold = {3{16'h0800}};
  logic [2:0][15:0] phase_curve_threshold = {3{16'hffff}};
  logic [2:0][15:0] residual_high_set_threshold = {3{16'h0800}};
  logic [2:0][15:0] residual_low_set_threshold = {3{16'h0800}};
  logic [2:0][15:0] residual_curve_threshold = {3{16'hffff}};
  logic [2:0][31:0] phase_high_set_delay = {3{32'h3}};
  logic [2:0][31:0] phase_low_set_delay = {3{32'h6}};
  logic [2:0][31:0] phase_curve_factor = {3{32'hffff}};
  logic [2:0][31:0] residual_high_set_delay = {3{32'h5}};
  logic [2:0][31:0] residual_low_set_delay = {3{32'h6}};
  logic [2:0][31:0] residual_curve_factor = {3{32'hffff}};
  logic [3:0][2:0][15:0] loc_phase_mag, loc_phase_h2;
  logic [3:0][15:0] loc_residual_mag, loc_residual_h2;
  logic [2:0][2:0][3:0] stage_pickup, stage_inrush, stage_expired, stage_trip;
  logic [2:0][3:0] path_inrush;
  logic [2:0] instance_active;
  logic group_pickup_flag, group_trip_flag;
  logic [15:0] ph_mag, ph_h2, res_mag;
  int miscompares = 0;
  int tests_run = 0;
  ocdt_front_end i_ocdt_front_end (.ref_clk, .ph_loc(phase_loc[0]),
    .res_loc(residual_loc[0]), .ph_mag, .ph_h2, .res_mag, .loc_phase_mag,
    .loc_phase_h2, .loc_residual_mag, .loc_residual_h2);
  ocdt_top i_ocdt_top (.ref_clk, .rstn, .object_is_1ph_busbar,
    .loc_phase_mag, .loc_residual_mag, .loc_phase_h2, .loc_residual_h2,
    .function_on, .phase_loc, .residual_loc, .phase_curve_on,
    .residual_curve_on, .inrush_restraint_on, .inrush_h2_ratio,
    .phase_high_set_threshold, .phase_high_set_delay,
    .phase_low_set_threshold, .phase_low_set_delay, .phase_curve_threshold,
    .phase_curve_factor, .residual_high_set_threshold,
    .residual_high_set_delay, .residual_low_set_threshold,
    .residual_low_set_delay, .residual_curve_threshold,
    .residual_curve_factor, .stage_pickup, .stage_inrush, .stage_expired,
    .stage_trip, .path_inrush, .instance_active, .group_pickup_flag,
    .group_trip_flag);
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // set the front-end magnitudes, then let n ticks pass
  task automatic apply(input logic [15:0] pm, ph, rm, input int n);
    ph_mag = pm;
    ph_h2 = ph;
    res_mag = rm;
    step(n);
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    #20000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    rstn = 1'b0;
    apply(16'h0, 16'h0, 16'h0, 12);
    check(stage_trip, 64'h0);
    rstn = 1'b1;
    step(3);
    check(instance_active, 3'h3);
    apply(16'h3000, 16'h0, 16'h0, 2);
    check(stage_pickup[0][0], 4'h1);
    check(stage_pickup[0][1], 4'h1);
    step(2);
    check(stage_trip[0][0], 4'h0);
    check(group_pickup_flag, 1'b1);
    step(1);
    check(stage_trip[0][0], 4'h1);
    check({stage_expired[0][1], group_trip_flag}, 5'h0);
    step(3);
    check(stage_trip[0][1], 4'h1);
    check(group_trip_flag, 1'b1);
    check(stage_pickup[1], 12'h0);
    $display("phase pickup test done");
    apply(16'h1e70, 16'h0, 16'h0, 3);
    check(stage_pickup[0][0], 4'h1);
    apply(16'h1e50, 16'h0, 16'h0, 3);
    check({stage_pickup[0][0], stage_expired[0][0]}, 8'h0);
    apply(16'h0670, 16'h0, 16'h0, 3);
    check(stage_pickup[0][1], 4'h1);
    apply(16'h0660, 16'h0, 16'h0, 3);
    check({stage_pickup[0][1], stage_trip[0][1]}, 8'h0);
    $display("phase dropout test done");
    apply(16'h0, 16'h0, 16'h0900, 3);
    check(stage_pickup[0][0], 4'h8);
    check(stage_pickup[0][1], 4'h8);
    apply(16'h0, 16'h0, 16'h0700, 3);
    check(stage_pickup[0][0], 4'h0);
    check(stage_pickup[0][1], 4'h8);
    apply(16'h0, 16'h0, 16'h0700, 3);
    check({stage_trip[0][1], stage_trip[0][0]}, 8'h80);
    apply(16'h0, 16'h0, 16'h0, 3);
    $display("residual test done");
    apply(16'h0, 16'h1000, 16'h0, 3);
    apply(16'h3000, 16'h1000, 16'h0, 10);
    check(path_inrush[0], 4'h1);
    check({stage_inrush[0][1], stage_pickup[0][1]}, 8'h10);
    check({stage_expired[0][1], stage_trip[0][1]}, 8'h10);
    check(stage_trip[0][0], 4'h1);
    $display("inrush test done");
    apply(16'h0, 16'h1000, 16'h0, 3);
    inrush_restraint_on = 3'h6;
    // bring the curve stage into reach: pickup at 0x1199, six ticks
    phase_curve_threshold = {3{16'h1000}};
    apply(16'h3000, 16'h1000, 16'h0, 10);
    check({stage_inrush[0][1], stage_trip[0][1]}, 8'h01);
    check({stage_pickup[0][2], stage_trip[0][2]}, 8'h11);
    $display("restraint off test done");
    object_is_1ph_busbar = 1'b1;
    step(3);
    check(stage_pickup, 64'h0);
    check(stage_trip, 64'h0);
    check({instance_active, group_pickup_flag, group_trip_flag}, 5'h0);
    $display("busbar test done");
    report_and_stop();
  end
endmodule // ocdt_top_test
`default_nettype wire
